/* File: sram_port_pkg.sv */
/*
 * constants shared by the pipelined synchronous memory port.
 * assumes a single 250 MHz clock and that all files are compiled together.
 */
// Function
// [R1] register every synchronous input on rising edge
// [R2] read data leaves through output registers
// [R3] clock qualify high freezes all state; here the synchronisers still run and data_oe still drops on output enable high
// [R4] back-to-back reads and writes, no waits
// [R5] byte lane selects gate each write byte
// [R6] writes complete internally, no pulse needed
// [R7] selected only when all three selects agree
// [R8] output enable high floats data outputs
// [R9] drivers off during write data phase
// [R10] linear or interleaved burst order selectable
// [R11] sleep input idles the port; clock stoppable
// [R12] array is 256K by 36 words
// [R13] data two enabled cycles after address
`default_nettype none
package sram_port_pkg;
   localparam int ADDR_W = 18;           // 256K words
   localparam int DATA_W = 36;           // four lanes of nine bits
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int BURST_W = 2;           // burst counter width
   localparam int DEPTH = 262144;        // words in the array
   localparam int FIFO_W = 36;           // write data fifo width
   localparam int FIFO_D = 16;           // write data fifo depth
   localparam int LAT = 2;               // enabled cycles address to data
   localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
endpackage
`default_nettype wire

/* File: write_fifo.sv */
/*
 * small synchronous fifo, valid/ready on both sides.
 * assumes one clock, a clock enable and an asynchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module write_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];        // storage
   logic [PW:0] wr_ptr;                   // extra bit tells full from empty
   logic [PW:0] rd_ptr;
   logic push;
   logic pop;
   logic full;
   logic empty;
   assign full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign push = ce && in_valid && !full;
   assign pop = ce && out_ready && !empty;
   assign out_data = mem[rd_ptr[PW-1:0]];
   // write side pointer and storage
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr[PW-1:0]] <= in_data;
      end
   end
   // read side pointer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: sram_port.sv */
/*
 * pipelined burst static memory port, 256K words of 36 bits.
 * a bus master on the same clock drives address and controls every cycle;
 * pins are sampled through two flops first, then the input register.
 * the shared data bus is split into in, out and output enable.
 */
`timescale 1ns/100ps
`default_nettype none
module sram_port
   import sram_port_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic clock_qualify_n,          // low enables the edge
   input wire logic chip_select_1_n,
   input wire logic chip_select_2,
   input wire logic chip_select_3_n,
   input wire logic write_n,
   input wire logic advance,                  // high continues a burst
   input wire logic interleave,               // static burst order select
   input wire logic sleep_request,
   input wire logic output_enable_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [LANES-1:0] byte_lane_write_n,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   output logic asleep
);
   // pin synchronisers, first stage read only by second
   // the bus is treated as arriving from another domain; both stages run
   // even when the clock is not qualified, so the qualify pin itself is seen
   logic [ADDR_W+LANES+DATA_W+9-1:0] sync1;
   logic [ADDR_W+LANES+DATA_W+9-1:0] sync2;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {clock_qualify_n, chip_select_1_n, chip_select_2, chip_select_3_n,
                   write_n, advance, interleave, sleep_request, output_enable_n,
                   addr, byte_lane_write_n, data_in};
         sync2 <= sync1;
      end
   end
   logic s_cq_n, s_cs1_n, s_cs2, s_cs3_n, s_we_n, s_adv, s_ilv, s_sleep, s_oe_n;
   logic [ADDR_W-1:0] s_addr;
   logic [LANES-1:0] s_bw_n;
   logic [DATA_W-1:0] s_din;
   assign {s_cq_n, s_cs1_n, s_cs2, s_cs3_n, s_we_n, s_adv, s_ilv, s_sleep, s_oe_n,
           s_addr, s_bw_n, s_din} = sync2;
   // the clock-enable: deasserted qualify extends the previous cycle
   logic ce;
   assign ce = !s_cq_n;                                   // R3

   // chip select decode, used for new accesses
   function automatic logic selected(input logic c1n, input logic c2, input logic c3n);
      selected = !c1n && c2 && !c3n;                      // R7
   endfunction

   // burst address within a four-word wrap
   function automatic logic [BURST_W-1:0] burst_next(input logic [BURST_W-1:0] base,
                                                     input logic [BURST_W-1:0] cnt,
                                                     input logic ilv);
      burst_next = ilv ? (base ^ cnt) : (base + cnt);     // R10
   endfunction

   // input register stage; every synchronised pin but qualify, interleave and output enable
   // is captured here on an enabled edge; the burst decode below reads interleave straight from sync2
   logic in_sel, in_we, in_adv;
   logic [ADDR_W-1:0] in_addr;
   logic [LANES-1:0] in_bw_n;
   // write data has an input register of its own: the word on the bus two
   // enabled cycles after its address lands here just as that write reaches
   // the end of the pipeline, so data and address meet without extra delay
   logic [DATA_W-1:0] in_din;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         in_sel <= 1'b0;
         in_we <= 1'b0;
         in_adv <= 1'b0;
         in_addr <= '0;
         in_bw_n <= '1;
         in_din <= '0;
      end else if (ce) begin                              // R3
         in_sel <= selected(s_cs1_n, s_cs2, s_cs3_n) && !s_sleep;   // R1 R11
         in_we <= !s_we_n;
         in_adv <= s_adv;
         in_addr <= s_addr;
         in_bw_n <= s_bw_n;                               // R1
         in_din <= s_din;                                 // R1 R13
      end
   end

   // burst tracking: an advance cycle repeats the last access type
   logic active, burst_we;
   logic [ADDR_W-1:0] base_addr;
   logic [BURST_W-1:0] burst_cnt;
   logic [BURST_W-1:0] next_cnt;
   assign next_cnt = burst_cnt + BURST_ONE;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         active <= 1'b0;
         burst_we <= 1'b0;
         base_addr <= '0;
         burst_cnt <= BURST_ZERO;
      end else if (ce) begin
         if (in_adv && active) begin
            burst_cnt <= next_cnt;                        // R10
         end else begin
            // an advance that arrives with no burst open starts nothing
            active <= in_sel && !in_adv;
            burst_we <= in_we;
            base_addr <= in_addr;
            burst_cnt <= BURST_ZERO;
         end
      end
   end
   // stage-one access: new command or burst continuation
   logic acc_valid, acc_we;
   logic [ADDR_W-1:0] acc_addr;
   logic [BURST_W-1:0] cont_cnt;
   assign cont_cnt = (in_adv && active) ? next_cnt : BURST_ZERO;
   always_comb begin
      if (in_adv && active) begin
         acc_valid = 1'b1;
         acc_we = burst_we;
         acc_addr = {base_addr[ADDR_W-1:BURST_W],
                     burst_next(base_addr[BURST_W-1:0], cont_cnt, s_ilv)};
      end else begin
         acc_valid = in_sel && !in_adv;
         acc_we = in_we;
         acc_addr = in_addr;
      end
   end

   // pipeline of pending accesses, data two enabled cycles later
   // address and lanes travel with each access, so a burst and a new command
   // can follow one another with no gap between them
   logic [LAT-1:0] p_valid, p_we;
   logic [ADDR_W-1:0] p_addr [LAT];
   logic [LANES-1:0] p_bw [LAT];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         p_valid <= '0;
         p_we <= '0;
         for (int i = 0; i < LAT; i++) begin
            p_addr[i] <= '0;
            p_bw[i] <= '1;
         end
      end else if (ce) begin                              // R4 R13
         p_valid[0] <= acc_valid;
         p_we[0] <= acc_we;
         p_addr[0] <= acc_addr;
         p_bw[0] <= in_bw_n;
         for (int i = 1; i < LAT; i++) begin
            p_valid[i] <= p_valid[i-1];
            p_we[i] <= p_we[i-1];
            p_addr[i] <= p_addr[i-1];
            p_bw[i] <= p_bw[i-1];
         end
      end
   end
   logic do_write, do_read;
   assign do_write = p_valid[LAT-1] && p_we[LAT-1];
   assign do_read = p_valid[LAT-1] && !p_we[LAT-1];

   // write data passes a fifo; it drains into the array each enabled cycle
   logic wf_in_ready, wf_out_valid;
   logic [FIFO_W-1:0] wf_out_data;
   // pushes and pops share an enabled edge, so it holds one word in practice;
   // the spare depth only matters should the drain ever be gated
   write_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) write_fifo_i (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .in_valid(do_write),
      .in_ready(wf_in_ready),
      .in_data(in_din),
      .out_valid(wf_out_valid),
      .out_ready(1'b1),
      .out_data(wf_out_data)
   );
   // address and lanes of buffered write, one enabled cycle behind
   logic w_pend;
   logic [ADDR_W-1:0] w_addr;
   logic [LANES-1:0] w_bw_n;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         w_pend <= 1'b0;
         w_addr <= '0;
         w_bw_n <= '1;
      end else if (ce) begin
         w_pend <= do_write && wf_in_ready;
         w_addr <= p_addr[LAT-1];
         w_bw_n <= p_bw[LAT-1];
      end
   end

   // memory array, self-timed internal write per lane
   logic [DATA_W-1:0] mem [DEPTH];                        // R12
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : lane
         always_ff @(posedge mclk) begin
            if (ce && w_pend && wf_out_valid && !w_bw_n[g]) begin   // R5 R6
               mem[w_addr][g*LANE_W +: LANE_W] <= wf_out_data[g*LANE_W +: LANE_W];
            end
         end
      end
   endgenerate

   // a read one cycle behind a write to the same word meets the array on the
   // very edge that stores that write, so the buffered lanes are merged in
   // here; without this the read would return the word as it was before
   logic fwd_hit;
   logic [DATA_W-1:0] rd_word;
   assign fwd_hit = w_pend && wf_out_valid && (w_addr == p_addr[LAT-1]);   // R4
   // read word: array contents with the buffered write lanes laid over them
   always_comb begin
      rd_word = mem[p_addr[LAT-1]];
      for (int l = 0; l < LANES; l++) begin
         if (fwd_hit && !w_bw_n[l]) begin                 // R5
            rd_word[l*LANE_W +: LANE_W] = wf_out_data[l*LANE_W +: LANE_W];
         end
      end
   end

   // read output register, updated only by an enabled read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_out <= '0;
      end else if (ce && do_read) begin                   // R2
         data_out <= rd_word;                             // R4
      end
   end
   // output driver enable: off during write data or when enable pin high
   // with the enable pin low it holds over unqualified edges and drops on the first enabled edge
   // without a read, so it is never up while a write's data is taken
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= !s_oe_n && (ce ? do_read : data_oe);  // R8 R9
      end
   end
   // sleep status; frozen like the pipeline while the clock is not qualified
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         asleep <= 1'b0;
      end else if (ce) begin                              // R3
         asleep <= s_sleep && !(|p_valid);                // R11
      end
   end

   chk_qualify_freeze: assert property (@(posedge mclk) disable iff (rst)   // R3
      !ce |=> $stable(p_valid) && $stable(data_out))
      else $error("state changed while clock qualify deasserted");
   chk_write_float: assert property (@(posedge mclk) disable iff (rst)      // R9
      (ce && do_write) |=> !data_oe)
      else $error("driver on during write data phase");
   chk_oe_float: assert property (@(posedge mclk) disable iff (rst)         // R8
      s_oe_n |=> !data_oe)
      else $error("driver on with output enable high");
   chk_read_drive: assert property (@(posedge mclk) disable iff (rst)       // R2
      (ce && do_read && !s_oe_n) |=> data_oe)
      else $error("read data not driven");
   // checks below watch internal state; all of them are quiet during reset
   // and count in enabled edges, since unqualified edges leave the pipeline unchanged
   chk_latency_two: assert property (@(posedge mclk) disable iff (rst)      // R13
      (ce && acc_valid) ##1 ce |=> p_valid[LAT-1])
      else $error("access not at pipeline end two enabled cycles later");
   chk_deselect_idle: assert property (@(posedge mclk) disable iff (rst)    // R7
      (ce && !in_adv && !in_sel) |=> !p_valid[0])
      else $error("deselected cycle started access");
   chk_sleep_nosel: assert property (@(posedge mclk) disable iff (rst)      // R11
      (ce && s_sleep) |=> !in_sel)
      else $error("access accepted in sleep");
   chk_lane_hold: assert property (@(posedge mclk) disable iff (rst)        // R4
      (ce && do_write) |-> wf_in_ready)
      else $error("write buffer refused data");
   chk_input_capture: assert property (@(posedge mclk) disable iff (rst)    // R1
      ce |=> (in_addr == $past(s_addr)) && (in_bw_n == $past(s_bw_n)))
      else $error("input register missed an enabled edge");
   chk_burst_block: assert property (@(posedge mclk) disable iff (rst)      // R10
      (in_adv && active) |-> (acc_addr[ADDR_W-1:BURST_W] == base_addr[ADDR_W-1:BURST_W]))
      else $error("burst left its four-word block");
   chk_write_commit: assert property (@(posedge mclk) disable iff (rst)     // R6
      (ce && do_write) |=> (w_pend && wf_out_valid))
      else $error("write not queued for the array");
   chk_sleep_flag: assert property (@(posedge mclk) disable iff (rst)       // R11
      (ce && s_sleep && !(|p_valid)) |=> asleep)
      else $error("sleep not reported with pipeline empty");
   // covers for the main traffic shapes, forwarding included
   cov_forward: cover property (@(posedge mclk) ce && do_read && fwd_hit);
   cov_read: cover property (@(posedge mclk) ce && do_read);
   cov_write: cover property (@(posedge mclk) ce && do_write);
   cov_turn: cover property (@(posedge mclk) (ce && do_write) ##1 (ce && do_read));
   cov_burst: cover property (@(posedge mclk) ce && in_adv && active);
endmodule
`default_nettype wire

/* File: bus_master_model.sv */
/*
 * bus master model: drives every input of the memory port but clock and reset, one slot a cycle.
 * assumes the port takes write data two enabled cycles after the address.
 */
`timescale 1ns/100ps
`default_nettype none
module bus_master_model
   import sram_port_pkg::*;
(
   input wire logic mclk,
   output logic clock_qualify_n,
   output logic chip_select_1_n,
   output logic chip_select_2,
   output logic chip_select_3_n,
   output logic write_n,
   output logic advance,
   output logic interleave,
   output logic sleep_request,
   output logic output_enable_n,
   output logic [ADDR_W-1:0] addr,
   output logic [LANES-1:0] byte_lane_write_n,
   output logic [DATA_W-1:0] data_in
);
   logic [DATA_W-1:0] wd [2]; // write data waiting for its data phase
   logic [1:0] wv; // which waiting slots hold a selected write
   // idle, deselected bus from time zero
   initial begin
      {clock_qualify_n, advance, interleave, sleep_request, output_enable_n} = 5'h0;
      {chip_select_1_n, chip_select_2, chip_select_3_n, write_n} = 4'hf;
      addr = '0;
      byte_lane_write_n = 4'hf;
      data_in = '0;
      wd = '{'0, '0};
      wv = 2'h0;
   end
   // one enabled bus cycle; cs is {select 1 low, select 2 high, select 3 low}
   task automatic op(input logic [2:0] cs, input logic wr, input logic adv,
                     input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
                     input logic [DATA_W-1:0] d);
      @(posedge mclk);
      #1;
      clock_qualify_n = 1'b0;
      {chip_select_1_n, chip_select_2, chip_select_3_n} = cs;
      write_n = !wr;
      advance = adv;
      addr = a;
      byte_lane_write_n = wr ? ln : 4'hf;
      // a released bus flips every cycle so a stale value never passes
      data_in = wv[1] ? wd[1] : ~data_in;
      wd[1] = wd[0];
      wv[1] = wv[0];
      wd[0] = d;
      wv[0] = wr && cs == 3'h2;
   endtask
   // ignored edges: qualify goes high and every other pin holds, so the data phase slides with them
   task automatic hold(input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
         clock_qualify_n = 1'b1;
      end
   endtask
   // static mode pins, changed only between accesses
   task automatic set_static(input logic ilv, input logic oe_n, input logic slp);
      @(posedge mclk);
      #1;
      interleave = ilv;
      output_enable_n = oe_n;
      sleep_request = slp;
   endtask
endmodule
`default_nettype wire

/* File: pipelined_sync_sram_port_bench.sv */
/*
 * testbench of the memory port, one task per scenario.
 * assumes the master model drives every input but clock and reset; reads are judged at data_oe.
 */
`timescale 1ns/100ps
`default_nettype none
module pipelined_sync_sram_port_bench;
   import sram_port_pkg::*;
   localparam logic [2:0] SEL = 3'h2; // the only selecting pattern
   localparam logic [2:0] OFF = 3'h7;
   localparam logic [DATA_W-1:0] D1 = 36'h123456789;
   localparam logic [DATA_W-1:0] D2 = 36'hfedcba987;
   localparam logic [DATA_W-1:0] M = {9'h000, 9'h1ff, 9'h000, 9'h1ff}; // lanes 0, 2
   localparam logic [DATA_W-1:0] E = (D2 & M) | (D1 & ~M); // merged word
   logic mclk = 1'b0;
   logic rst = 1'b1;
   wire logic cq_n, cs1_n, cs2, cs3_n, wr_n, adv, ilv, slp, oe_n, data_oe, asleep;
   wire logic [ADDR_W-1:0] addr;
   wire logic [LANES-1:0] lanes_n;
   wire logic [DATA_W-1:0] d_in, d_out;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [DATA_W-1:0] q;
   always #2 mclk = ~mclk;
   // the run needs well under 1000 cycles; beyond 3000 something hangs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         stop_test();
      end
   end
   sram_port sram_port_i (.mclk(mclk), .rst(rst), .clock_qualify_n(cq_n),
      .chip_select_1_n(cs1_n), .chip_select_2(cs2), .chip_select_3_n(cs3_n),
      .write_n(wr_n), .advance(adv), .interleave(ilv), .sleep_request(slp),
      .output_enable_n(oe_n), .addr(addr), .byte_lane_write_n(lanes_n),
      .data_in(d_in), .data_out(d_out), .data_oe(data_oe), .asleep(asleep));
   bus_master_model bus_master_model_i (.mclk(mclk), .clock_qualify_n(cq_n),
      .chip_select_1_n(cs1_n), .chip_select_2(cs2), .chip_select_3_n(cs3_n),
      .write_n(wr_n), .advance(adv), .interleave(ilv), .sleep_request(slp),
      .output_enable_n(oe_n), .addr(addr), .byte_lane_write_n(lanes_n),
      .data_in(d_in));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string what, input logic [DATA_W-1:0] exp,
                        input logic [DATA_W-1:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic op(input logic [2:0] cs, input logic w, input logic a_v,
                     input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
                     input logic [DATA_W-1:0] d);
      bus_master_model_i.op(cs, w, a_v, a, ln, d);
   endtask
   task automatic idle();
      op(OFF, 1'b0, 1'b0, '0, 4'hf, '0);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      op(SEL, 1'b0, 1'b0, a, 4'hf, '0);
   endtask
   // idle until read data shows; q stays unknown if it never does
   task automatic get();
      q = 'x;
      for (int i = 0; i < 12; i++) begin
         idle();
         if (data_oe === 1'b1) begin
            q = d_out;
            break;
         end
      end
   endtask
   // data_oe must stay low for eight idle cycles
   task automatic quiet(input string what);
      repeat (8) begin
         idle();
         check(what, '0, DATA_W'(data_oe));
      end
   endtask
   task automatic t_basic();
      op(SEL, 1'b1, 1'b0, 18'h5, 4'h0, D1);
      op(SEL, 1'b1, 1'b0, 18'h3ffff, 4'h0, ~D1);
      repeat (3) idle();
      rd(18'h5);
      rd(18'h3ffff);
      get();
      check("word", D1, q);
      idle();
      check("top word", ~D1, d_out);
      op(SEL, 1'b1, 1'b0, 18'h5, 4'ha, D2);
      repeat (3) idle();
      rd(18'h5);
      get();
      check("lanes", E, q);
   endtask
   // write, read, write, read on consecutive cycles
   task automatic t_turn();
      op(SEL, 1'b1, 1'b0, 18'ha, 4'h0, D2);
      rd(18'h5);
      op(SEL, 1'b1, 1'b0, 18'hb, 4'h0, D1);
      rd(18'h5);
      get();
      check("turn read", E, q);
      repeat (2) idle();
      check("second read", E, d_out);
      repeat (3) idle();
      rd(18'ha);
      rd(18'hb);
      get();
      check("turn word a", D2, q);
      idle();
      check("turn word b", D1, d_out);
      // a read right behind two writes to one word sees both of them
      op(SEL, 1'b1, 1'b0, 18'he, 4'h0, D2);
      op(SEL, 1'b1, 1'b0, 18'he, 4'ha, D1);
      rd(18'he);
      get();
      check("forwarded lanes", (D1 & M) | (D2 & ~M), q);
   endtask
   // each select wrong in turn: no write, no read data
   task automatic t_select();
      logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
      op(SEL, 1'b1, 1'b0, 18'hc, 4'h0, D1);
      foreach (bad[i]) begin
         op(bad[i], 1'b1, 1'b0, 18'hc, 4'h0, D2);
         op(bad[i], 1'b0, 1'b0, 18'hc, 4'hf, '0);
         quiet("deselected data_oe");
      end
      rd(18'hc);
      get();
      check("deselected write", D1, q);
   endtask
   task automatic t_oe();
      bus_master_model_i.set_static(1'b0, 1'b1, 1'b0);
      rd(18'h5);
      quiet("disabled data_oe");
      bus_master_model_i.set_static(1'b0, 1'b0, 1'b0);
   endtask
   // ignored edges keep the write data phase and a pending read intact
   task automatic t_stall();
      op(SEL, 1'b1, 1'b0, 18'hd, 4'h0, D2);
      bus_master_model_i.hold(4);
      repeat (3) idle();
      rd(18'hd);
      bus_master_model_i.hold(3);
      get();
      check("stalled word", D2, q);
   endtask
   task automatic t_burst();
      for (int i = 0; i < 4; i++) op(SEL, 1'b1, 1'b0, 18'h14 + i, 4'h0, 36'h5a5a5a5a0 + i);
      for (int m = 0; m < 2; m++) begin
         repeat (3) idle();
         bus_master_model_i.set_static(m[0], 1'b0, 1'b0);
         rd(18'h15);
         repeat (3) op(SEL, 1'b0, 1'b1, '0, 4'hf, '0);
         get();
         for (int k = 0; k < 4; k++) begin
            if (k > 0) idle();
            if (k > 0) q = d_out;
            check("burst", 36'h5a5a5a5a0 + (m ? (1 ^ k) : ((1 + k) & 3)), q);
         end
      end
      bus_master_model_i.set_static(1'b0, 1'b0, 1'b0);
   endtask
   task automatic t_sleep();
      bus_master_model_i.set_static(1'b0, 1'b0, 1'b1);
      repeat (12) idle();
      check("asleep", 36'h1, DATA_W'(asleep));
      rd(18'h5);
      quiet("sleeping data_oe");
      bus_master_model_i.set_static(1'b0, 1'b0, 1'b0);
      repeat (12) idle();
      check("awake", '0, DATA_W'(asleep));
      rd(18'h5);
      get();
      check("after sleep", E, q);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (2) idle();
      t_basic();
      t_turn();
      t_select();
      t_oe();
      t_stall();
      t_burst();
      t_sleep();
      stop_test();
   end
endmodule
`default_nettype wire
